// ---- common/res_pwm_pkg.sv ----
// Constants, register map and carrier types of the resonant period limiter.
package res_pwm_pkg;
    // =====================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned UNIT_NS = 5;
    localparam int unsigned CYCLES_PER_UNIT_RAW = UNIT_NS / CLK_PERIOD_NS;
    localparam int unsigned CYCLES_PER_UNIT = (CYCLES_PER_UNIT_RAW < 1) ? 1 : CYCLES_PER_UNIT_RAW;
    localparam int unsigned DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLES_PER_UNIT - 1);

    // =====================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MAX_HI = 8'h42;
    localparam logic [7:0] IDX_MAX_LO = 8'h44;
    localparam logic [7:0] IDX_MIN_HI = 8'h46;
    localparam logic [7:0] IDX_FALL_B = 8'h47;
    localparam logic [7:0] IDX_MIN_LO = 8'h48;
    localparam logic [7:0] IDX_CTRL = 8'h50;
    localparam logic [7:0] IDX_CMD = 8'h51;
    localparam logic [7:0] IDX_STATUS = 8'h52;

    // =====================================================
    // Field positions and widths
    localparam int unsigned PER_W = 12;
    localparam int unsigned LOW_MSB = 7;
    localparam int unsigned LOW_LSB = 4;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned STATUS_ACTIVE_BIT = 12;
    localparam int unsigned STATUS_OUT_BIT = 13;
    localparam logic [PER_W-1:0] PERIOD_FLOOR = 12'h001;

    // =====================================================
    // Reset values
    localparam logic [7:0] RST_MAX_HI = 8'hff;
    localparam logic [7:0] RST_MAX_LO = 8'hf0;
    localparam logic [7:0] RST_MIN_HI = 8'h00;
    localparam logic [7:0] RST_FALL_B = 8'h00;
    localparam logic [7:0] RST_MIN_LO = 8'h00;
    localparam logic [PER_W-1:0] RST_CMD = 12'h000;

    // =====================================================
    // Carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_type;

    typedef enum logic [3:0] {
        SEL_NONE, SEL_MAX_HI, SEL_MAX_LO, SEL_MIN_HI, SEL_FALL_B,
        SEL_MIN_LO, SEL_CTRL, SEL_CMD, SEL_STATUS
    } reg_sel_type;
endpackage

// ---- rtl/res_period_limiter.sv ----
// Resonant PWM period limiter and second bridge output falling edge placement.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
// Operation
// - Min period: 0x46 high, 0x48[7:4] low.
// - One period unit weighs 5 ns.
// - Never run cycle shorter than minimum.
// - Code 0x80 leads midpoint by 640 ns.
// - Lead shrinks 5 ns per code step.
// - Max period: 0x42 high, 0x44[7:4] low.
module res_period_limiter (
    input wire logic pclk,
    input wire logic presetn,
    input res_pwm_pkg::apb_req_type apb_req,
    output res_pwm_pkg::apb_rsp_type apb_rsp,
    output logic bridge_output_second,
    output logic cycle_start
);
    import res_pwm_pkg::*;

    typedef struct packed {
        logic [7:0] max_hi;
        logic [7:0] max_lo;
        logic [7:0] min_hi;
        logic [7:0] fall_b;
        logic [7:0] min_lo;
        logic enable;
        logic [PER_W-1:0] cmd;
    } regs_type;

    typedef struct packed {
        regs_type regs;
        apb_rsp_type rsp;
        logic [DIV_W-1:0] div;
        logic active;
        logic [PER_W-1:0] cnt;
        logic [PER_W-1:0] period;
        logic [7:0] code;
        logic [PER_W-1:0] fall;
        logic out;
        logic start;
    } state_type;

    state_type q;
    state_type d;

    // =====================================================
    // Address decoding
    function automatic reg_sel_type decode(input logic [11:0] addr);
        reg_sel_type sel;
        sel = SEL_NONE;
        if (addr == {2'b00, IDX_MAX_HI, 2'b00}) begin
            sel = SEL_MAX_HI;
        end else if (addr == {2'b00, IDX_MAX_LO, 2'b00}) begin
            sel = SEL_MAX_LO;
        end else if (addr == {2'b00, IDX_MIN_HI, 2'b00}) begin
            sel = SEL_MIN_HI;
        end else if (addr == {2'b00, IDX_FALL_B, 2'b00}) begin
            sel = SEL_FALL_B;
        end else if (addr == {2'b00, IDX_MIN_LO, 2'b00}) begin
            sel = SEL_MIN_LO;
        end else if (addr == {2'b00, IDX_CTRL, 2'b00}) begin
            sel = SEL_CTRL;
        end else if (addr == {2'b00, IDX_CMD, 2'b00}) begin
            sel = SEL_CMD;
        end else if (addr == {2'b00, IDX_STATUS, 2'b00}) begin
            sel = SEL_STATUS;
        end
        return sel;
    endfunction

    logic [PER_W-1:0] min_p;
    logic [PER_W-1:0] max_p;
    logic [PER_W-1:0] clamped;
    logic [PER_W-1:0] mid_n;
    logic signed [PER_W+1:0] fall_s;
    logic wr_fire;
    logic tick;
    reg_sel_type rsel;
    reg_sel_type wsel;

    // =====================================================
    // Limits and clamping
    always_comb begin
        min_p = {q.regs.min_hi, q.regs.min_lo[LOW_MSB:LOW_LSB]};
        max_p = {q.regs.max_hi, q.regs.max_lo[LOW_MSB:LOW_LSB]};
        clamped = q.regs.cmd;
        if (clamped > max_p) begin
            clamped = max_p;
        end
        if (clamped < min_p) begin
            clamped = min_p;
        end
        if (clamped < PERIOD_FLOOR) begin
            clamped = PERIOD_FLOOR;
        end
        mid_n = clamped >> 1;
        fall_s = $signed({2'b00, mid_n}) + $signed({{(PER_W-6){q.regs.fall_b[7]}}, q.regs.fall_b});
        wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite && q.rsp.pready;
        tick = (q.div == DIV_LAST);
        rsel = decode(apb_req.paddr);
        wsel = rsel;
    end

    // =====================================================
    // Next state
    always_comb begin
        d = q;
        d.rsp.pready = 1'b0;
        d.rsp.pslverr = 1'b0;
        d.start = 1'b0;

        if (apb_req.psel && !apb_req.penable) begin
            d.rsp.pready = 1'b1;
            d.rsp.prdata = 32'h0000_0000;
            if (rsel == SEL_MAX_HI) begin
                d.rsp.prdata[7:0] = q.regs.max_hi;
            end else if (rsel == SEL_MAX_LO) begin
                d.rsp.prdata[7:0] = q.regs.max_lo;
            end else if (rsel == SEL_MIN_HI) begin
                d.rsp.prdata[7:0] = q.regs.min_hi;
            end else if (rsel == SEL_FALL_B) begin
                d.rsp.prdata[7:0] = q.regs.fall_b;
            end else if (rsel == SEL_MIN_LO) begin
                d.rsp.prdata[7:0] = q.regs.min_lo;
            end else if (rsel == SEL_CTRL) begin
                d.rsp.prdata[CTRL_EN_BIT] = q.regs.enable;
            end else if (rsel == SEL_CMD) begin
                d.rsp.prdata[PER_W-1:0] = q.regs.cmd;
            end else if (rsel == SEL_STATUS) begin
                d.rsp.prdata[PER_W-1:0] = q.period;
                d.rsp.prdata[STATUS_ACTIVE_BIT] = q.active;
                d.rsp.prdata[STATUS_OUT_BIT] = q.out;
            end else begin
                d.rsp.pslverr = 1'b1;
            end
        end

        if (wr_fire) begin
            if (wsel == SEL_MAX_HI) begin
                d.regs.max_hi = apb_req.pwdata[7:0];
            end else if (wsel == SEL_MAX_LO) begin
                d.regs.max_lo = apb_req.pwdata[7:0];
            end else if (wsel == SEL_MIN_HI) begin
                d.regs.min_hi = apb_req.pwdata[7:0];
            end else if (wsel == SEL_FALL_B) begin
                d.regs.fall_b = apb_req.pwdata[7:0];
            end else if (wsel == SEL_MIN_LO) begin
                d.regs.min_lo = apb_req.pwdata[7:0];
            end else if (wsel == SEL_CTRL) begin
                d.regs.enable = apb_req.pwdata[CTRL_EN_BIT];
            end else if (wsel == SEL_CMD) begin
                d.regs.cmd = apb_req.pwdata[PER_W-1:0];
            end
        end

        if (!q.regs.enable) begin
            d.active = 1'b0;
            d.div = '0;
            d.cnt = '0;
        end else if (!q.active || (tick && q.cnt == q.period - PERIOD_FLOOR)) begin
            // Period and offset are latched only at a cycle boundary.
            d.active = 1'b1;
            d.div = '0;
            d.cnt = '0;
            d.period = clamped;
            d.code = q.regs.fall_b;
            d.start = 1'b1;
            if (fall_s < 0) begin
                d.fall = '0;
            end else if (fall_s > $signed({2'b00, clamped})) begin
                d.fall = clamped;
            end else begin
                d.fall = fall_s[PER_W-1:0];
            end
        end else begin
            // one count per 5 ns unit
            d.div = tick ? '0 : q.div + 1'b1;
            if (tick) begin
                d.cnt = q.cnt + 1'b1;
            end
        end
        d.out = d.active && (d.cnt < d.fall);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.regs.max_hi <= RST_MAX_HI;
            q.regs.max_lo <= RST_MAX_LO;
            q.regs.min_hi <= RST_MIN_HI;
            q.regs.fall_b <= RST_FALL_B;
            q.regs.min_lo <= RST_MIN_LO;
            q.regs.cmd <= RST_CMD;
            q.period <= PERIOD_FLOOR;
        end else begin
            q <= d;
        end
    end

    assign apb_rsp = q.rsp;
    assign bridge_output_second = q.out;
    assign cycle_start = q.start;

    // =====================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_min_hi_write;
        wr_fire && wsel == SEL_MIN_HI;
    endsequence

    sequence s_min_lo_write;
        wr_fire && wsel == SEL_MIN_LO;
    endsequence

    a_min_high_bits: assert property (s_min_hi_write |=> min_p[11:4] == $past(apb_req.pwdata[7:0]))
        else $error("minimum period high bits not taken from write");
    a_min_low_bits: assert property (s_min_lo_write |=> min_p[3:0] == $past(apb_req.pwdata[7:4]))
        else $error("minimum period low bits not taken from write");
    a_max_period_bits: assert property (wr_fire && wsel == SEL_MAX_LO |=> max_p[3:0] == $past(apb_req.pwdata[7:4]))
        else $error("maximum period low bits not taken from write");
    a_period_floor: assert property ($rose(q.start) |-> q.period >= $past(min_p))
        else $error("cycle shorter than minimum period");
    a_period_ceiling: assert property ($rose(q.start) && $past(min_p <= max_p && max_p >= PERIOD_FLOOR)
        |-> q.period <= $past(max_p))
        else $error("cycle longer than maximum period");
    a_period_pass: assert property (q.start
        && $past(q.regs.cmd >= min_p && q.regs.cmd <= max_p && q.regs.cmd != 0) |-> q.period == $past(q.regs.cmd))
        else $error("in-range command was altered");
    a_unit_length: assert property (q.active && q.regs.enable && tick && q.cnt != q.period - PERIOD_FLOOR
        |=> q.cnt == $past(q.cnt) + 1'b1 && !q.start)
        else $error("period count not one per unit");
    a_trailing_fall: assert property (q.start && !q.code[7] && ({1'b0, q.period >> 1} + q.code) <= q.period
        |-> q.fall == (q.period >> 1) + q.code)
        else $error("trailing fall edge misplaced");
    a_lead_640: assert property (q.start && q.code == 8'h80 && (q.period >> 1) >= 12'h080
        |-> q.fall == (q.period >> 1) - 12'h080)
        else $error("code 0x80 does not lead by 640 ns");
    a_lead_step: assert property (q.start && q.code[7] && (q.period >> 1) >= 12'h080
        |-> (q.period >> 1) - q.fall == 12'h100 - {4'h0, q.code})
        else $error("leading offset step wrong");
    a_fall_edge: assert property (q.active && $past(q.active) && $fell(q.out) |-> q.cnt == q.fall)
        else $error("output fell away from its fall point");
endmodule

// ---- verification/switch_driver_model.sv ----
// Switch driver model that measures each switching cycle of the second bridge output.
`timescale 1ns/100ps
module switch_driver_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic drive_in,
    input wire logic cycle_start,
    output logic meas_valid,
    output logic [11:0] meas_period,
    output logic [11:0] meas_high
);
    // =====================================================
    // Measurement
    logic [11:0] cnt_q;
    logic [11:0] high_q;
    logic seen_q;
    // A cycle is reported only once a full cycle has been seen since reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {meas_valid, meas_period, meas_high, cnt_q, high_q, seen_q} <= '0;
        end else if (cycle_start) begin
            meas_valid <= seen_q;
            meas_period <= cnt_q;
            meas_high <= high_q;
            cnt_q <= 12'h001;
            high_q <= {11'h000, drive_in};
            seen_q <= 1'b1;
        end else begin
            meas_valid <= 1'b0;
            cnt_q <= cnt_q + 12'h001;
            high_q <= high_q + {11'h000, drive_in};
        end
    end
endmodule

// ---- verification/res_period_limiter_tb_top.sv ----
// Self-checking bench for the resonant period limiter.
`timescale 1ns/100ps
module res_period_limiter_tb_top;
    import res_pwm_pkg::*;
    // =====================================================
    // Signals and instances
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_type req = '0;
    apb_rsp_type rsp;
    logic out_b;
    logic start;
    logic meas_valid;
    logic [11:0] meas_period;
    logic [11:0] meas_high;
    logic [32:0] rd_q[$];
    logic [23:0] pwm_q[$];
    int miscompares = 0;
    int num_checks = 0;
    int seed = 75064;
    logic [11:0] last_p = 12'h001;
    always #2.5 pclk = ~pclk;
    res_period_limiter res_period_limiter_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .bridge_output_second(out_b), .cycle_start(start));
    switch_driver_model switch_driver_model_inst (.pclk(pclk), .presetn(presetn), .drive_in(out_b),
        .cycle_start(start), .meas_valid(meas_valid), .meas_period(meas_period), .meas_high(meas_high));
    // =====================================================
    // Checking
    task automatic check_reg(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: read data and error %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic check_pwm(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: period and high time %h, expected %h", $time, got, exp);
        end
    endtask
    always @(posedge pclk) begin
        if (rsp.pready === 1'b1 && req.pwrite === 1'b0 && rd_q.size() > 0) check_reg({rsp.prdata, rsp.pslverr}, rd_q.pop_front());
        if (meas_valid === 1'b1 && pwm_q.size() > 0) check_pwm({meas_period, meas_high}, pwm_q.pop_front());
    end
    // Period is clamped to max, then min, then one; fall point is half period plus signed offset.
    function automatic logic [23:0] pwm_exp(logic [11:0] c, logic [11:0] mn, logic [11:0] mx, logic [7:0] code);
        int p;
        int f;
        p = c;
        if (p > mx) p = mx;
        if (p < mn) p = mn;
        if (p < 1) p = 1;
        f = p / 2 + $signed(code);
        if (f < 0) f = 0;
        if (f > p) f = p;
        return {12'(p), 12'(f)};
    endfunction
    // =====================================================
    // Stimulus
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
        if (!wr) rd_q.push_back(exp);
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic run_case(input logic [11:0] c, input logic [11:0] mn, input logic [11:0] mx, input logic [7:0] code);
        logic [23:0] e;
        apb(1'b1, 12'h140, 32'h0, 33'h0);
        apb(1'b0, 12'h148, 32'h0, {18'h0, 2'b00, last_p, 1'b0});
        apb(1'b1, 12'h118, {24'h0, mn[11:4]}, 33'h0);
        apb(1'b1, 12'h120, {24'h0, mn[3:0], 4'h5}, 33'h0);
        apb(1'b1, 12'h108, {24'h0, mx[11:4]}, 33'h0);
        apb(1'b1, 12'h110, {24'h0, mx[3:0], 4'ha}, 33'h0);
        apb(1'b1, 12'h11c, {24'h0, code}, 33'h0);
        apb(1'b1, 12'h144, {20'h0, c}, 33'h0);
        apb(1'b0, 12'h120, 32'h0, {24'h0, mn[3:0], 4'h5, 1'b0});
        apb(1'b0, 12'h144, 32'h0, {20'h0, c, 1'b0});
        apb(1'b1, 12'h140, 32'h1, 33'h0);
        apb(1'b0, 12'h140, 32'h0, {32'h0000_0001, 1'b0});
        @(posedge pclk iff meas_valid === 1'b1);
        @(negedge pclk);
        e = pwm_exp(c, mn, mx, code);
        pwm_q.push_back(e);
        last_p = e[23:12];
        @(posedge pclk iff meas_valid === 1'b1);
        @(negedge pclk);
    endtask
    task automatic finish_test;
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h108, 32'h0, {32'h0000_00ff, 1'b0});
        apb(1'b0, 12'h110, 32'h0, {32'h0000_00f0, 1'b0});
        apb(1'b0, 12'h118, 32'h0, 33'h0);
        apb(1'b0, 12'h11c, 32'h0, 33'h0);
        apb(1'b1, 12'h004, 32'h5a, 33'h0);
        apb(1'b0, 12'h004, 32'h0, 33'h1);
        run_case(12'd40, 12'd20, 12'd100, 8'h00);
        run_case(12'd10, 12'd20, 12'd100, 8'h05);
        run_case(12'd200, 12'd20, 12'd100, 8'h80);
        run_case(12'd300, 12'd16, 12'd400, 8'h7f);
        run_case(12'd300, 12'd16, 12'd400, 8'h80);
        run_case(12'd300, 12'd16, 12'd400, 8'hff);
        run_case(12'd50, 12'd90, 12'd60, 8'h81);
        for (int i = 0; i < 6; i++) begin
            run_case(12'($random(seed) & 32'h1ff), 12'($random(seed) & 32'h1ff), 12'($random(seed) & 32'h1ff),
                8'($random(seed)));
        end
        finish_test;
    end
endmodule
